/* hdl/mr_init_dev.v */
// Device-side tracker of reset, initialization and mode register programming.
// Assumes link pins arrive asynchronously and an AHB-Lite master owns the registers.
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mr_init_defs.vh"
module mr_init_dev #(
  parameter IDLE_CYC = `IDLE_TIME_MS * `MCLK_MHZ * 1000
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire ck,
  input wire reset_n,
  input wire cke,
  input wire cs_n,
  input wire act_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bg,
  input wire [1:0] ba,
  input wire [17:0] a,
  input wire odt,
  input wire ten,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg dev_ready_q
);
  // ==========================================================
  // Pin synchronization
  wire [31:0] pins;
  pin_sync #(.W(32)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_in({ten, ck, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a, odt}),
    .pin_out(pins)
  );
  wire s_ck = pins[30];
  wire s_rstn = pins[29];
  wire s_cke = pins[28];
  wire s_cs_n = pins[27];
  wire s_act_n = pins[26];
  wire s_ras_n = pins[25];
  wire s_cas_n = pins[24];
  wire s_we_n = pins[23];
  wire [2:0] s_sel = {pins[21], pins[20:19]};
  wire s_bg1 = pins[22];
  wire [17:0] s_a = pins[18:1];
  wire s_odt = pins[0];
  wire s_ten = pins[31];

  reg ck_q;
  reg rstn_q;
  reg cke_q;
  reg cs_n_q;
  wire ck_rise = s_ck & ~ck_q;

  // ==========================================================
  // Command decode on each link clock rising edge
  wire cmd_sel = s_cke & ~s_cs_n & s_act_n;
  wire is_mrs = cmd_sel & ~s_ras_n & ~s_cas_n & ~s_we_n;
  wire is_ref = cmd_sel & ~s_ras_n & ~s_cas_n & s_we_n;
  wire is_zqcl = cmd_sel & s_ras_n & s_cas_n & ~s_we_n & s_a[10];
  wire is_other = s_cke & ~s_cs_n & ~is_mrs & ~is_ref & ~is_zqcl;
  wire [2:0] mr_idx = s_sel;

  // ==========================================================
  // Control state
  localparam S_RST = 3'd0;
  localparam S_CKE = 3'd1;
  localparam S_XPR = 3'd2;
  localparam S_MRS = 3'd3;
  localparam S_ZQ = 3'd4;
  localparam S_READY = 3'd5;

  reg [2:0] state_q;
  reg [6:0] mask_q;
  reg [17:0] mr_q [0:6];
  reg [15:0] since_mrs_q;
  reg [15:0] xpr_q;
  reg [15:0] dll_q;
  reg dll_run_q;
  reg [15:0] zq_q;
  reg zq_run_q;
  reg exempt_q;
  reg [31:0] idle_q;
  reg [3:0] ckelow_q;
  reg [31:0] refcnt_q;
  reg [`ERR_W-1:0] err_q;
  reg [`ERR_W-1:0] err_set;
  reg [15:0] tmrd_q;
  reg [15:0] tmod_q;
  reg [15:0] tdllk_q;
  reg [15:0] tzq_q;
  reg [6:0] exmask_q;

  wire rtt_on = mr_q[1][10:8] != 3'h0;
  wire mrd_ok = exempt_q | (since_mrs_q >= tmrd_q);
  wire mod_ok = exempt_q | (since_mrs_q >= tmod_q);
  wire dll_done = ~dll_run_q & (dll_q >= tdllk_q);
  wire zq_done = ~zq_run_q & (zq_q >= tzq_q);

  // ==========================================================
  // Bus side write strobes
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire bus_take = hsel & hready & htrans[1];
  wire [31:0] w1c = (wr_pend_q && wr_addr_q == `REG_ERR) ? hwdata : 32'h0;

  integer k;
  always @* begin
    err_set = {`ERR_W{1'b0}};
    if (ce && ck_rise) begin
      if (is_mrs && mr_idx == 3'b111) begin
        err_set[`ERR_SEL] = 1'b1;
      end
      if (is_mrs && state_q >= S_MRS && !mrd_ok) begin
        err_set[`ERR_MRD] = 1'b1;
      end
      if ((is_other || is_ref || is_zqcl) && state_q >= S_MRS && !mod_ok) begin
        err_set[`ERR_MOD] = 1'b1;
      end
      if ((is_other || is_ref) && (state_q == S_MRS || state_q == S_XPR)) begin
        err_set[`ERR_INITCMD] = 1'b1;
      end
      if (is_zqcl && state_q == S_MRS && mask_q != 7'h7f) begin
        err_set[`ERR_INCOMPLETE] = 1'b1;
      end
      if (!s_cs_n && state_q == S_ZQ) begin
        err_set[`ERR_EARLY] = 1'b1;
      end
      // Termination must be off across MRS only when it is in use
      if (rtt_on && s_odt && (is_mrs || (state_q >= S_MRS && !mod_ok))) begin
        err_set[`ERR_ODT] = 1'b1;
      end
      // A mode set with CKE low never decodes as is_mrs, so match its pins here
      if (!s_cke && !s_cs_n && s_act_n && !s_ras_n && !s_cas_n && !s_we_n
          && state_q == S_READY) begin
        err_set[`ERR_MRD] = 1'b1;
      end
      if (is_mrs && state_q == S_XPR && xpr_q < `TXPR_CK) begin
        err_set[`ERR_XPR] = 1'b1;
      end
    end
    if (ce && state_q == S_READY && idle_q >= IDLE_CYC - 1) begin
      err_set[`ERR_IDLE] = 1'b1;
    end
    if (ce && !s_rstn && s_ten) begin
      err_set[`ERR_TEN] = 1'b1;
    end
    if (ce && s_rstn && !rstn_q && ckelow_q < `CKE_SETUP_CYC) begin
      err_set[`ERR_CKE] = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= S_RST;
      mask_q <= 7'h00;
      since_mrs_q <= 16'h0000;
      xpr_q <= 16'h0000;
      dll_q <= 16'h0000;
      dll_run_q <= 1'b0;
      zq_q <= 16'h0000;
      zq_run_q <= 1'b0;
      exempt_q <= 1'b0;
      idle_q <= 32'h00000000;
      ckelow_q <= 4'h0;
      refcnt_q <= 32'h00000000;
      err_q <= {`ERR_W{1'b0}};
      ck_q <= 1'b0;
      rstn_q <= 1'b0;
      cke_q <= 1'b0;
      cs_n_q <= 1'b1;
      dev_ready_q <= 1'b0;
      for (k = 0; k < 7; k = k + 1) begin
        mr_q[k] <= 18'h00000;
      end
    end else if (ce) begin
      ck_q <= s_ck;
      rstn_q <= s_rstn;
      cke_q <= s_cke;
      cs_n_q <= s_cs_n;
      // Set wins over a simultaneous software clear
      err_q <= (err_q & ~w1c[`ERR_W-1:0]) | err_set;
      if (s_cke) begin
        ckelow_q <= 4'h0;
      end else if (ckelow_q != 4'hf) begin
        ckelow_q <= ckelow_q + 4'h1;
      end
      dev_ready_q <= (state_q == S_READY);
      if (!s_rstn) begin
        // Link reset clears every counter but the refresh count and the CKE-low count
        state_q <= S_RST;
        mask_q <= 7'h00;
        since_mrs_q <= 16'h0000;
        xpr_q <= 16'h0000;
        dll_q <= 16'h0000;
        dll_run_q <= 1'b0;
        zq_q <= 16'h0000;
        zq_run_q <= 1'b0;
        exempt_q <= 1'b0;
        idle_q <= 32'h00000000;
      end else begin
        if (state_q == S_READY && (is_ref && ck_rise || s_cke != cke_q || s_cs_n != cs_n_q
            || idle_q >= IDLE_CYC - 1)) begin
          idle_q <= 32'h00000000;
        end else if (state_q == S_READY) begin
          idle_q <= idle_q + 32'h00000001;
        end
        if (ck_rise) begin
          if (since_mrs_q != 16'hffff) begin
            since_mrs_q <= since_mrs_q + 16'h0001;
          end
          if (dll_run_q) begin
            dll_q <= dll_q + 16'h0001;
            dll_run_q <= (dll_q + 16'h0001) < tdllk_q;
          end
          if (zq_run_q) begin
            zq_q <= zq_q + 16'h0001;
            zq_run_q <= (zq_q + 16'h0001) < tzq_q;
          end
          if (is_ref) begin
            refcnt_q <= refcnt_q + 32'h00000001;
          end
          if (is_mrs && mr_idx != 3'b111) begin
            // Whole register replaced; only mode storage is written here, never data
            mr_q[mr_idx] <= s_a;
            mask_q[mr_idx] <= 1'b1;
            since_mrs_q <= 16'h0000;
            exempt_q <= exmask_q[mr_idx];
            if (mr_idx == 3'd0 && s_a[8]) begin
              dll_q <= 16'h0000;
              dll_run_q <= 1'b1;
            end
          end
          if (is_zqcl) begin
            zq_q <= 16'h0000;
            zq_run_q <= 1'b1;
          end
          case (state_q)
            S_RST: begin
              state_q <= S_CKE;
            end
            S_CKE: begin
              if (s_cke) begin
                state_q <= S_XPR;
                xpr_q <= 16'h0000;
              end
            end
            S_XPR: begin
              if (xpr_q != 16'hffff) begin
                xpr_q <= xpr_q + 16'h0001;
              end
              if (is_mrs) begin
                state_q <= S_MRS;
              end
            end
            S_MRS: begin
              if (is_zqcl) begin
                state_q <= S_ZQ;
              end
            end
            S_ZQ: begin
              if (dll_done && zq_done) begin
                state_q <= S_READY;
              end
            end
            S_READY: begin
              state_q <= S_READY;
            end
            default: begin
              state_q <= S_RST;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, read data registered at address phase
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `REG_STATUS: rd_mux = {20'h00000, dev_ready_q, mask_q, 1'b0, state_q};
      `REG_ERR: rd_mux = {21'h000000, err_q};
      `REG_TMRD: rd_mux = {16'h0000, tmrd_q};
      `REG_TMOD: rd_mux = {16'h0000, tmod_q};
      `REG_TDLLK: rd_mux = {16'h0000, tdllk_q};
      `REG_TZQINIT: rd_mux = {16'h0000, tzq_q};
      `REG_EXEMPT: rd_mux = {25'h0000000, exmask_q};
      `REG_REFCNT: rd_mux = refcnt_q;
      default: begin
        if (haddr[7:0] >= `REG_MR_BASE && haddr[7:0] <= `REG_MR_LAST && haddr[1:0] == 2'b00) begin
          rd_mux = {14'h0000, mr_q[haddr[4:2]]};
        end
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      tmrd_q <= `TMRD_RST;
      tmod_q <= `TMOD_RST;
      tdllk_q <= `TDLLK_RST;
      tzq_q <= `TZQINIT_RST;
      exmask_q <= `EXEMPT_RST;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= bus_take & hwrite;
      wr_addr_q <= haddr[7:0];
      if (bus_take && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_q) begin
        case (wr_addr_q)
          `REG_TMRD: tmrd_q <= hwdata[15:0];
          `REG_TMOD: tmod_q <= hwdata[15:0];
          `REG_TDLLK: tdllk_q <= hwdata[15:0];
          `REG_TZQINIT: tzq_q <= hwdata[15:0];
          `REG_EXEMPT: exmask_q <= hwdata[6:0];
          default: tmrd_q <= tmrd_q;
        endcase
      end
    end
  end
endmodule // mr_init_dev
`default_nettype wire

/* hdl/mr_init_defs.vh */
// Constants for the mode register and initialization tracker of a DDR4 device.
// Assumes a 125 MHz system clock and a slow link clock sampled as a plain input.
`ifndef MR_INIT_DEFS_VH
`define MR_INIT_DEFS_VH

// ==========================================================
// Register offsets (byte addresses)
`define REG_STATUS 8'h00
`define REG_ERR 8'h04
`define REG_TMRD 8'h08
`define REG_TMOD 8'h0c
`define REG_TDLLK 8'h10
`define REG_TZQINIT 8'h14
`define REG_EXEMPT 8'h18
`define REG_REFCNT 8'h1c
`define REG_MR_BASE 8'h20
`define REG_MR_LAST 8'h38

// ==========================================================
// Reset values of the timing limits in link clock cycles, the exemption mask reset value and the fixed TXPR_CK limit
`define TMRD_RST 16'h0008
`define TMOD_RST 16'h0018
`define TDLLK_RST 16'h0300
`define TZQINIT_RST 16'h0400
`define EXEMPT_RST 7'h78
`define TXPR_CK 16'h0005

// ==========================================================
// Time figures and derived system clock counts
`define MCLK_MHZ 125
`define IDLE_TIME_MS 960
`define CKE_SETUP_NS 10
`define CKE_SETUP_CYC ((`CKE_SETUP_NS * `MCLK_MHZ + 999) / 1000)

// ==========================================================
// Error flag positions
`define ERR_SEL 0
`define ERR_MRD 1
`define ERR_MOD 2
`define ERR_INITCMD 3
`define ERR_INCOMPLETE 4
`define ERR_EARLY 5
`define ERR_ODT 6
`define ERR_IDLE 7
`define ERR_TEN 8
`define ERR_CKE 9
`define ERR_XPR 10
`define ERR_W 11

// Status fields
`define ST_STATE_LSB 0
`define ST_MASK_LSB 4
`define ST_READY_BIT 11

`endif

/* hdl/pin_sync.v */
// Three-stage synchronizer for a group of pins from outside the mclk domain.
// The output follows once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 31
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge mclk) begin
        if (sys_rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end else if (ce) begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Only the later two stages are compared; the first may be metastable
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign pin_out[i] = out_q;
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

/* verification/ctl_model.sv */
// Behavioural memory controller that drives the link pins of the mode register tracker.
// Assumes the tracker samples the pins on mclk; commands change on ck falling edges.
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  output logic ck,
  output logic reset_n,
  output logic cke,
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [17:0] a,
  output logic odt,
  output logic ten
);
  // ==========================================================
  // Link clock and pin defaults
  // Offset keeps ck edges clear of mclk edges
  initial begin
    ck = 1'b0;
    #3.3;
    forever #80 ck = ~ck;
  end
  initial begin
    {reset_n, cke, odt, ten} = 4'h0;
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
    {bg, ba, a} = '0;
  end
  task automatic des(input int n);
    repeat (n) @(negedge ck);
  endtask
  // Kind 1 mode set, 2 long calibration, 3 refresh, 4 read
  task automatic cmd(input int k, input logic [2:0] mr, input logic [17:0] v);
    @(negedge ck);
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = (k == 1) ? 3'b000 : (k == 2) ? 3'b110 :
      (k == 3) ? 3'b001 : 3'b101;
    {bg, ba} = {1'b0, mr};
    a = v;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    // Released address bus must not look like the last value
    a = ~v;
  endtask
  task automatic pwr(input int xpr, input logic t);
    @(negedge ck);
    cke = 1'b0;
    reset_n = 1'b0;
    // A high t breaks the test-enable rule while reset is held
    ten = t;
    des(2);
    ten = 1'b0;
    des(2);
    reset_n = 1'b1;
    des(4);
    cke = 1'b1;
    des(xpr);
  endtask
endmodule // ctl_model
`default_nettype wire

/* verification/mr_init_dev_monitor.sv */
// Concurrent checks on the ports of the mode register tracker.
// Assumes one mclk domain with synchronous active-high sys_rst.
`timescale 1ns/1ps
`default_nettype none
module mr_init_chk #(
  parameter IDLE_CYC = 2000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dev_ready_q
);
  // ==========================================================
  // Helper counters and assertions
  logic rd_take;
  logic [7:0] hi_q;
  logic [3:0] lo_q;
  assign rd_take = hsel & hready & htrans[1] & ~hwrite & ce;
  always @(posedge mclk) begin
    if (sys_rst || !reset_n) begin
      hi_q <= 8'h00;
    end else if (hi_q != 8'hff) begin
      hi_q <= hi_q + 8'h01;
    end
  end
  always @(posedge mclk) begin
    if (sys_rst) begin
      lo_q <= 4'hf;
    end else if (!reset_n) begin
      lo_q <= 4'h0;
    end else if (lo_q != 4'hf) begin
      lo_q <= lo_q + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence link_rst_held;
    (!reset_n && ce) [*8];
  endsequence
  sequence rd_unmapped;
    rd_take && haddr[7:2] >= 6'h0f;
  endsequence
  a_bus_ready: assert property (hreadyout) else $error("hreadyout low");
  a_bus_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_unmapped_zero: assert property (rd_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rst_clears: assert property (disable iff (1'b0) sys_rst && ce |=>
    hrdata == 32'h0 && !dev_ready_q) else $error("reset left state");
  a_link_rst_drop: assert property (link_rst_held |-> !dev_ready_q)
    else $error("ready kept during link reset");
  a_ready_late: assert property ($rose(dev_ready_q) |-> hi_q >= 8'd200)
    else $error("ready too soon after link reset");
  a_drop_cause: assert property ($fell(dev_ready_q) |-> lo_q <= 4'd12)
    else $error("ready fell without link reset");
endmodule // mr_init_chk
bind mr_init_dev mr_init_chk #(.IDLE_CYC(IDLE_CYC)) u_chk (.mclk, .sys_rst, .ce, .reset_n,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .dev_ready_q);
`default_nettype wire

/* verification/ddr4_init_and_mode_register_programming_bench.sv */
// Bench for the mode register tracker: link traffic from the controller model, registers
// over AHB-Lite. Assumes shortened limits written at start and a small idle window.
`timescale 1ns/1ps
`default_nettype none
`include "mr_init_defs.vh"
module ddr4_init_and_mode_register_programming_bench;
  typedef struct {string nm; logic [31:0] e;} note_t;
  localparam int IDLE = 2000;
  logic mclk, sys_rst, ce, hsel, hwrite, rdv;
  logic ce_rnd = 1'b0;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  wire ck, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, ten, hreadyout, hresp, dev_ready_q;
  wire [1:0] bg, ba;
  wire [17:0] a;
  wire [31:0] hrdata;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 82;
  int order[7] = '{3, 6, 5, 4, 2, 1, 0};
  logic [31:0] ra[5] = '{`REG_TMRD, `REG_TMOD, `REG_TDLLK, `REG_TZQINIT, `REG_EXEMPT};
  logic [31:0] rv[5] = '{`TMRD_RST, `TMOD_RST, `TDLLK_RST, `TZQINIT_RST, `EXEMPT_RST};
  logic [31:0] wv[5] = '{32'h2, 32'h4, 32'h40, 32'h30, 32'h78};
  logic [17:0] mrv[7];
  note_t q[$];
  note_t nt;
  ctl_model u_ctl (.ck, .reset_n, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .a,
    .odt, .ten);
  mr_init_dev #(.IDLE_CYC(IDLE)) u_dut (.mclk, .sys_rst, .ce, .ck, .reset_n, .cke, .cs_n,
    .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .a, .odt, .ten, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dev_ready_q);
  always #4 mclk = ~mclk;
  // Random stalls only while the link runs; bus transfers need ce held high
  always @(posedge mclk) ce <= !ce_rnd || ($random(seed) & 3) != 0;
  // ==========================================================
  // Checking, bus tasks and result watcher
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hwait();
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    haddr <= ad;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdv <= ~w;
    hwait();
    rdv <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [31:0] ad, input logic [31:0] e);
    q.push_back(note_t'{nm, e});
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic wait_ready();
    int n = 0;
    while (dev_ready_q !== 1'b1 && n < 90) begin
      u_ctl.des(1);
      n++;
    end
    check("ready", {31'h0, dev_ready_q}, 32'h1);
    if (dev_ready_q !== 1'b1) begin
      finish_test();
    end
  endtask
  always @(posedge mclk) begin
    if (rdv && hreadyout) begin
      nt = q.pop_front();
      check(nt.nm, hrdata, nt.e);
    end
  end
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    mclk = 1'b0;
    {sys_rst, hsel, hwrite, rdv} = 4'b1000;
    {htrans, haddr, hwdata} = '0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd("limit rst", ra[i], rv[i]);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ra[i], wv[i]);
      rd("limit rw", ra[i], wv[i]);
    end
    rd("unmapped", 32'h3c, 32'h0);
    bus(1'b1, `REG_REFCNT, 32'h5);
    rd("refcnt ro", `REG_REFCNT, 32'h0);
    rd("status rst", `REG_STATUS, 32'h0);
    for (int i = 0; i < 7; i++) mrv[i] = 18'($random(seed));
    mrv[1][0] = 1'b1;
    mrv[0][8] = 1'b1;
    // Termination off in MR1, so a high ODT must pass unflagged
    mrv[1][10:8] = 3'h0;
    u_ctl.odt = 1'b1;
    ce_rnd = 1'b1;
    u_ctl.pwr(6, 1'b0);
    foreach (order[i]) begin
      u_ctl.cmd(1, order[i][2:0], mrv[order[i]]);
      u_ctl.des(4);
    end
    u_ctl.des(6);
    u_ctl.cmd(2, 3'h0, 18'h00400);
    u_ctl.des(50);
    check("ready early", {31'h0, dev_ready_q}, 32'h0);
    wait_ready();
    ce_rnd = 1'b0;
    u_ctl.odt = 1'b0;
    rd("status", `REG_STATUS, 32'hff5);
    rd("err", `REG_ERR, 32'h0);
    for (int i = 0; i < 7; i++) rd("mr value", `REG_MR_BASE + 4 * i, {14'h0, mrv[i]});
    repeat (3) u_ctl.cmd(3, 3'h0, 18'h0);
    rd("refcnt", `REG_REFCNT, 32'h3);
    rd("err busy", `REG_ERR, 32'h0);
    repeat (IDLE + 600) @(posedge mclk);
    rd("err idle", `REG_ERR, 32'h80);
    bus(1'b1, `REG_ERR, 32'hfff);
    rd("err clear", `REG_ERR, 32'h0);
    // Second start-up breaks spacing, select, termination and command rules on purpose
    u_ctl.pwr(2, 1'b1);
    rd("status again", `REG_STATUS, 32'h2);
    u_ctl.cmd(1, 3'h3, mrv[3]);
    u_ctl.cmd(1, 3'h6, mrv[6]);
    u_ctl.des(4);
    u_ctl.cmd(1, 3'h7, 18'h0);
    u_ctl.des(4);
    u_ctl.cmd(1, 3'h5, mrv[5]);
    u_ctl.des(4);
    u_ctl.cmd(1, 3'h4, mrv[4]);
    u_ctl.des(4);
    u_ctl.cmd(1, 3'h2, mrv[2]);
    u_ctl.cmd(1, 3'h1, 18'h00101);
    u_ctl.odt = 1'b1;
    u_ctl.des(2);
    u_ctl.odt = 1'b0;
    u_ctl.des(4);
    u_ctl.cmd(1, 3'h0, mrv[0]);
    u_ctl.cmd(4, 3'h0, 18'h0);
    u_ctl.des(6);
    u_ctl.cmd(2, 3'h0, 18'h00400);
    wait_ready();
    rd("err faults", `REG_ERR, 32'h54f);
    rd("refcnt kept", `REG_REFCNT, 32'h3);
    rd("mr1 value", `REG_MR_BASE + 4, 32'h101);
    rd("status again", `REG_STATUS, 32'hff5);
    bus(1'b1, `REG_ERR, 32'hfff);
    u_ctl.cke = 1'b0;
    u_ctl.cmd(1, 3'h2, mrv[2]);
    u_ctl.cke = 1'b1;
    rd("err cke low", `REG_ERR, 32'h2);
    finish_test();
  end
endmodule // ddr4_init_and_mode_register_programming_bench
`default_nettype wire
